// File: rtl/agccs_cs_detect.v
// Carrier-sense decision from RSSI against absolute and relative thresholds
`timescale 1ns/1ns
`include "agccs_regs.vh"

module agccs_cs_detect (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// Receiver
	input wire rxStart,
	input wire [7:0] rssi,
	// Settings
	input wire [7:0] goalDb,
	input wire [3:0] absThr,
	input wire [1:0] relThr,
	// Decision
	output wire csHit
);

reg [7:0] rssiFloor;
reg [7:0] relDb;
wire [9:0] absLevel;
wire [9:0] relLevel;
wire absHit;
wire relHit;

// ----------------------------------------
// RSSI floor for the relative check
// ----------------------------------------
always @(posedge mclk) begin
	if (!rstn)
		rssiFloor <= `AGCCS_RST_DATA;
	else if (rxStart || rssi < rssiFloor)
		rssiFloor <= rssi;
end

always @* begin
	case (relThr)
		`AGCCS_CODE_1: relDb = `AGCCS_REL_DB_1;
		`AGCCS_CODE_2: relDb = `AGCCS_REL_DB_2;
		`AGCCS_CODE_3: relDb = `AGCCS_REL_DB_3;
		default: relDb = `AGCCS_RST_DATA;
	endcase
end

// ----------------------------------------
// Threshold compare
// ----------------------------------------
// Signed offset in 1 dB steps around the goal
assign absLevel = {2'b00, goalDb} + {{6{absThr[3]}}, absThr};
assign relLevel = {2'b00, rssiFloor} + {2'b00, relDb};
assign absHit = (absThr != `AGCCS_ABS_OFF) && ({2'b00, rssi} >= absLevel);
assign relHit = (relThr != `AGCCS_CODE_0) && ({2'b00, rssi} >= relLevel);
assign csHit = absHit | relHit;

endmodule // agccs_cs_detect

// File: rtl/agccs_gain_loop.v
// Gain loop control registers, gain stepping, averaging and carrier sense
//
// What this block does
// - Order bit one: lower first LNA first
// - Order bit zero: second stage to minimum first
// - Relative threshold: off, 6, 10, 14 dB
// - Absolute threshold signed, 1 dB steps, around goal
// - Absolute code 1000 disables absolute check
// - Codes 1001..0111 span minus to plus 7 dB
// - Hysteresis code picks dead zone size
// - Skip 8/16/24/32 samples after gain change
// - Hold code 00: always adjust gain
// - Sync policy: hold gain after sync word
// - Analog hold: only digital gain moves
// - Full hold: no gain moves, software overrides
// - Averaging over 8/16/32/64 samples
// - Averaging length sets on-off keying boundary
// - Goal codes map to 24..42 dB
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "agccs_regs.vh"

module agccs_gain_loop (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// Register port
	input wire [15:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdata,
	// Receiver side
	input wire rxStart,
	input wire sampleValid,
	input wire [7:0] sampleAmp,
	input wire [7:0] rssi,
	input wire syncFound,
	input wire [2:0] goalCode,
	input wire ookMode,
	// Software gain override
	input wire overrideLoad,
	input wire [1:0] overrideLna,
	input wire [1:0] overrideLna2,
	input wire [2:0] overrideDvga,
	// Gain and detection
	output reg [1:0] lnaGain,
	output reg [1:0] lna2Gain,
	output reg [2:0] dvgaGain,
	output reg carrierSense,
	output reg gainFrozen,
	output reg ookData
);

// ----------------------------------------
// Tables
// ----------------------------------------
function [7:0] goalDbOf;
	input [2:0] code;
	begin
		case (code)
			3'h0: goalDbOf = `AGCCS_GOAL_DB_0;
			3'h1: goalDbOf = `AGCCS_GOAL_DB_1;
			3'h2: goalDbOf = `AGCCS_GOAL_DB_2;
			3'h3: goalDbOf = `AGCCS_GOAL_DB_3;
			3'h4: goalDbOf = `AGCCS_GOAL_DB_4;
			3'h5: goalDbOf = `AGCCS_GOAL_DB_5;
			3'h6: goalDbOf = `AGCCS_GOAL_DB_6;
			default: goalDbOf = `AGCCS_GOAL_DB_7;
		endcase
	end
endfunction

function [6:0] waitOf;
	input [1:0] code;
	begin
		case (code)
			`AGCCS_CODE_0: waitOf = `AGCCS_WAIT_0;
			`AGCCS_CODE_1: waitOf = `AGCCS_WAIT_1;
			`AGCCS_CODE_2: waitOf = `AGCCS_WAIT_2;
			default: waitOf = `AGCCS_WAIT_3;
		endcase
	end
endfunction

function [6:0] avgLenOf;
	input [1:0] code;
	begin
		case (code)
			`AGCCS_CODE_0: avgLenOf = `AGCCS_AVG_0;
			`AGCCS_CODE_1: avgLenOf = `AGCCS_AVG_1;
			`AGCCS_CODE_2: avgLenOf = `AGCCS_AVG_2;
			default: avgLenOf = `AGCCS_AVG_3;
		endcase
	end
endfunction

// Divide by the window length without a divider
function [7:0] avgOf;
	input [13:0] sum;
	input [1:0] code;
	begin
		case (code)
			`AGCCS_CODE_0: avgOf = sum[10:3];
			`AGCCS_CODE_1: avgOf = sum[11:4];
			`AGCCS_CODE_2: avgOf = sum[12:5];
			default: avgOf = sum[13:6];
		endcase
	end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrlB;
reg [7:0] ctrlC;

wire orderLnaFirst = ctrlB[`AGCCS_B_ORDER];
wire [1:0] relThr = ctrlB[`AGCCS_B_REL];
wire [3:0] absThr = ctrlB[`AGCCS_B_ABS];
wire [1:0] hystCode = ctrlC[`AGCCS_C_HYST];
wire [1:0] waitCode = ctrlC[`AGCCS_C_WAIT];
wire [1:0] holdCode = ctrlC[`AGCCS_C_HOLD];
wire [1:0] filtCode = ctrlC[`AGCCS_C_FILT];

always @(posedge mclk) begin
	if (!rstn) begin
		ctrlB <= `AGCCS_RST_CTRL_B;
		ctrlC <= `AGCCS_RST_CTRL_C;
	end else if (regWr) begin
		if (regAddr == `AGCCS_ADDR_CTRL_B)
			ctrlB <= {1'b0, regWdata[`AGCCS_B_USED]};
		if (regAddr == `AGCCS_ADDR_CTRL_C)
			ctrlC <= regWdata;
	end
end

// Unmapped reads answer zero
always @(posedge mclk) begin
	if (!rstn)
		regRdata <= `AGCCS_RST_DATA;
	else if (regRd) begin
		case (regAddr)
			`AGCCS_ADDR_CTRL_B: regRdata <= ctrlB;
			`AGCCS_ADDR_CTRL_C: regRdata <= ctrlC;
			`AGCCS_ADDR_STAT_GAIN: regRdata <= {1'b0, dvgaGain, lna2Gain, lnaGain};
			`AGCCS_ADDR_STAT_FLAG: regRdata <= {5'h00, ookData, gainFrozen, carrierSense};
			default: regRdata <= `AGCCS_RST_DATA;
		endcase
	end else
		regRdata <= `AGCCS_RST_DATA;
end

// ----------------------------------------
// Dead zone
// ----------------------------------------
reg [7:0] hystUp;
reg [7:0] hystDn;

// Larger codes widen the upper side more: asymmetric
always @* begin
	case (hystCode)
		`AGCCS_CODE_0: begin
			hystUp = `AGCCS_HYST_UP_0;
			hystDn = `AGCCS_HYST_DN_0;
		end
		`AGCCS_CODE_1: begin
			hystUp = `AGCCS_HYST_UP_1;
			hystDn = `AGCCS_HYST_DN_0;
		end
		`AGCCS_CODE_2: begin
			hystUp = `AGCCS_HYST_UP_2;
			hystDn = `AGCCS_HYST_DN_0;
		end
		default: begin
			hystUp = `AGCCS_HYST_UP_3;
			hystDn = `AGCCS_HYST_DN_3;
		end
	endcase
end

// ----------------------------------------
// Freeze policy
// ----------------------------------------
reg syncHeld;

always @(posedge mclk) begin
	if (!rstn)
		syncHeld <= 1'b0;
	// Set wins over a restart in the same cycle so a found sync is never lost
	else if (syncFound && holdCode == `AGCCS_HOLD_SYNC)
		syncHeld <= 1'b1;
	else if (rxStart)
		syncHeld <= 1'b0;
end

wire holdAll = (holdCode == `AGCCS_HOLD_ALL) ||
	(holdCode == `AGCCS_HOLD_SYNC && syncHeld);
wire holdAnalog = holdAll || holdCode == `AGCCS_HOLD_ANALOG;

always @(posedge mclk) begin
	if (!rstn)
		gainFrozen <= 1'b0;
	else
		gainFrozen <= holdAll;
end

// ----------------------------------------
// Settle and averaging sequence
// ----------------------------------------
localparam ST_SETTLE = 2'b01;
localparam ST_ACCUM = 2'b10;

reg [1:0] state;
reg [6:0] count;
reg [13:0] sum;
reg [7:0] avgAmp;
reg avgDone;

wire [13:0] sumNext = sum + {6'h00, sampleAmp};
wire [6:0] countNext = count + 7'h01;
wire gainStep;

always @(posedge mclk) begin
	if (!rstn) begin
		state <= ST_SETTLE;
		count <= 7'h00;
		sum <= 14'h0000;
		avgAmp <= `AGCCS_RST_DATA;
		avgDone <= 1'b0;
	end else begin
		avgDone <= 1'b0;
		if (rxStart || gainStep) begin
			state <= ST_SETTLE;
			count <= 7'h00;
			sum <= 14'h0000;
		end else if (sampleValid) begin
			case (state)
				ST_SETTLE: begin
					if (countNext >= waitOf(waitCode)) begin
						state <= ST_ACCUM;
						count <= 7'h00;
					end else
						count <= countNext;
				end
				ST_ACCUM: begin
					if (countNext >= avgLenOf(filtCode)) begin
						avgAmp <= avgOf(sumNext, filtCode);
						avgDone <= 1'b1;
						count <= 7'h00;
						sum <= 14'h0000;
					end else begin
						count <= countNext;
						sum <= sumNext;
					end
				end
				default: begin
					state <= ST_SETTLE;
					count <= 7'h00;
					sum <= 14'h0000;
				end
			endcase
		end
	end
end

// ----------------------------------------
// Gain stepping
// ----------------------------------------
wire [7:0] goalDb = goalDbOf(goalCode);
wire [9:0] upperLevel = {2'b00, goalDb} + {2'b00, hystUp};
wire [9:0] lowerLevel = {2'b00, goalDb} - {2'b00, hystDn};
wire tooStrong = avgDone && ({2'b00, avgAmp} > upperLevel);
wire tooWeak = avgDone && ({2'b00, avgAmp} < lowerLevel);

reg [1:0] next_lna;
reg [1:0] next_lna2;
reg [2:0] next_dvga;

always @* begin
	next_lna = lnaGain;
	next_lna2 = lna2Gain;
	next_dvga = dvgaGain;
	if (holdAll) begin
		next_lna = lnaGain;
	end else if (tooStrong) begin
		if (!holdAnalog && orderLnaFirst && lnaGain != `AGCCS_LNA_MIN)
			next_lna = lnaGain - 2'h1;
		else if (!holdAnalog && lna2Gain != `AGCCS_LNA_MIN)
			next_lna2 = lna2Gain - 2'h1;
		else if (!holdAnalog && lnaGain != `AGCCS_LNA_MIN)
			next_lna = lnaGain - 2'h1;
		else if (dvgaGain != `AGCCS_DVGA_MIN)
			next_dvga = dvgaGain - 3'h1;
	end else if (tooWeak) begin
		// Digital first so analog steps stay rare
		if (dvgaGain != `AGCCS_DVGA_MAX)
			next_dvga = dvgaGain + 3'h1;
		else if (!holdAnalog && orderLnaFirst && lna2Gain != `AGCCS_LNA_MAX)
			next_lna2 = lna2Gain + 2'h1;
		else if (!holdAnalog && lnaGain != `AGCCS_LNA_MAX)
			next_lna = lnaGain + 2'h1;
		else if (!holdAnalog && lna2Gain != `AGCCS_LNA_MAX)
			next_lna2 = lna2Gain + 2'h1;
	end
end

assign gainStep = (next_lna != lnaGain) || (next_lna2 != lna2Gain) ||
	(next_dvga != dvgaGain);

always @(posedge mclk) begin
	if (!rstn) begin
		lnaGain <= `AGCCS_LNA_MAX;
		lna2Gain <= `AGCCS_LNA_MAX;
		dvgaGain <= `AGCCS_DVGA_MAX;
	end else if (overrideLoad && holdAll) begin
		lnaGain <= overrideLna;
		lna2Gain <= overrideLna2;
		dvgaGain <= overrideDvga;
	end else begin
		lnaGain <= next_lna;
		lna2Gain <= next_lna2;
		dvgaGain <= next_dvga;
	end
end

// ----------------------------------------
// Keyed-amplitude slicer
// ----------------------------------------
// The boundary is the last window average, so its length sets the slicer
always @(posedge mclk) begin
	if (!rstn)
		ookData <= 1'b0;
	else if (ookMode && sampleValid)
		ookData <= sampleAmp >= avgAmp;
end

// ----------------------------------------
// Carrier sense
// ----------------------------------------
wire csHit;

agccs_cs_detect u_agccs_cs_detect (
	.mclk(mclk),
	.rstn(rstn),
	.rxStart(rxStart),
	.rssi(rssi),
	.goalDb(goalDb),
	.absThr(absThr),
	.relThr(relThr),
	.csHit(csHit)
);

always @(posedge mclk) begin
	if (!rstn)
		carrierSense <= 1'b0;
	else
		carrierSense <= csHit;
end

endmodule // agccs_gain_loop

// File: rtl/agccs_regs.vh
// Register map, field layout, reset values and tables of the gain loop
`ifndef AGCCS_REGS_VH
`define AGCCS_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define AGCCS_ADDR_CTRL_B 16'hDF18
`define AGCCS_ADDR_CTRL_C 16'hDF19
`define AGCCS_ADDR_STAT_GAIN 16'hDF40
`define AGCCS_ADDR_STAT_FLAG 16'hDF41

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AGCCS_RST_CTRL_B 8'h40
`define AGCCS_RST_CTRL_C 8'h91
`define AGCCS_RST_DATA 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AGCCS_B_ORDER 6
`define AGCCS_B_REL 5:4
`define AGCCS_B_ABS 3:0
`define AGCCS_B_USED 6:0
`define AGCCS_C_HYST 7:6
`define AGCCS_C_WAIT 5:4
`define AGCCS_C_HOLD 3:2
`define AGCCS_C_FILT 1:0

// ----------------------------------------
// Codes
// ----------------------------------------
`define AGCCS_CODE_0 2'h0
`define AGCCS_CODE_1 2'h1
`define AGCCS_CODE_2 2'h2
`define AGCCS_CODE_3 2'h3
`define AGCCS_HOLD_NONE 2'h0
`define AGCCS_HOLD_SYNC 2'h1
`define AGCCS_HOLD_ANALOG 2'h2
`define AGCCS_HOLD_ALL 2'h3
`define AGCCS_ABS_OFF 4'h8

// ----------------------------------------
// Tables in dB and samples
// ----------------------------------------
`define AGCCS_REL_DB_1 8'h06
`define AGCCS_REL_DB_2 8'h0A
`define AGCCS_REL_DB_3 8'h0E
`define AGCCS_GOAL_DB_0 8'h18
`define AGCCS_GOAL_DB_1 8'h1B
`define AGCCS_GOAL_DB_2 8'h1E
`define AGCCS_GOAL_DB_3 8'h21
`define AGCCS_GOAL_DB_4 8'h24
`define AGCCS_GOAL_DB_5 8'h26
`define AGCCS_GOAL_DB_6 8'h28
`define AGCCS_GOAL_DB_7 8'h2A
`define AGCCS_WAIT_0 7'h08
`define AGCCS_WAIT_1 7'h10
`define AGCCS_WAIT_2 7'h18
`define AGCCS_WAIT_3 7'h20
`define AGCCS_AVG_0 7'h08
`define AGCCS_AVG_1 7'h10
`define AGCCS_AVG_2 7'h20
`define AGCCS_AVG_3 7'h40
`define AGCCS_HYST_UP_0 8'h02
`define AGCCS_HYST_UP_1 8'h03
`define AGCCS_HYST_UP_2 8'h04
`define AGCCS_HYST_UP_3 8'h06
`define AGCCS_HYST_DN_0 8'h02
`define AGCCS_HYST_DN_3 8'h03

// ----------------------------------------
// Gain ranges
// ----------------------------------------
`define AGCCS_LNA_MAX 2'h3
`define AGCCS_DVGA_MAX 3'h7
`define AGCCS_LNA_MIN 2'h0
`define AGCCS_DVGA_MIN 3'h0

`endif

// File: sim/agccs_gain_loop_bench.sv
// Self-checking bench for the gain loop register bank
`timescale 1ns/1ns
`include "agccs_regs.vh"

module agccs_gain_loop_bench;
	// ----------
	// Signals and expected state
	// ----------
	localparam [15:0] adB = `AGCCS_ADDR_CTRL_B, adC = `AGCCS_ADDR_CTRL_C;
	localparam [15:0] adG = `AGCCS_ADDR_STAT_GAIN, adF = `AGCCS_ADDR_STAT_FLAG;
	reg mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, rxStart = 1'b0;
	reg sampleValid = 1'b0, syncFound = 1'b0, ookMode = 1'b0, overrideLoad = 1'b0;
	reg [15:0] regAddr = 16'h0000;
	reg [7:0] regWdata = 8'h00, sampleAmp = 8'h00, rssi = 8'h00;
	reg [2:0] goalCode = 3'h0, overrideDvga = 3'h0;
	reg [1:0] overrideLna = 2'h0, overrideLna2 = 2'h0;
	wire [7:0] regRdata;
	wire [1:0] lnaGain, lna2Gain;
	wire [2:0] dvgaGain;
	wire carrierSense, gainFrozen, ookData;
	reg [1:0] mL = 2'h3, mL2 = 2'h3;
	reg [2:0] mD = 3'h7;
	reg ordBit = 1'b1, rdSeen = 1'b0;
	reg [7:0] winAmp = 8'h64;
	reg [3:0] c;
	reg [7:0] expQ [$], mskQ [$];
	integer errorCnt = 0, cmpCount = 0, k, thr, rnd;
	integer goalTab [0:7] = '{24, 27, 30, 33, 36, 38, 40, 42};
	integer relTab [0:3] = '{0, 6, 10, 14};

	agccs_gain_loop u_agccs_gain_loop (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .rxStart, .sampleValid, .sampleAmp, .rssi, .syncFound, .goalCode, .ookMode,
		.overrideLoad, .overrideLna, .overrideLna2, .overrideDvga, .lnaGain, .lna2Gain,
		.dvgaGain, .carrierSense, .gainFrozen, .ookData);

	always #2 mclk = ~mclk;

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		rdSeen <= regRd && rstn;
		if (rdSeen) check(regRdata & mskQ.pop_front(), expQ.pop_front());
	end

	task check(input [7:0] seen, input [7:0] exp);
		cmpCount = cmpCount + 1;
		if (seen !== exp) begin
			errorCnt = errorCnt + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wrapUp;
		$display("errors %0d compares %0d", errorCnt, cmpCount);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task wr(input [15:0] a, input [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		// Idle edge: back-to-back calls never drive a strobe twice at once
		@(posedge mclk);
	endtask

	task rd(input [15:0] a, input [7:0] e, input [7:0] m);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back(e & m);
		mskQ.push_back(m);
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
	endtask

	task feed(input integer n, input [7:0] amp);
		repeat (n) begin
			sampleValid <= 1'b1;
			sampleAmp <= amp;
			@(posedge mclk);
		end
		sampleValid <= 1'b0;
	endtask

	task rxGo;
		rxStart <= 1'b1;
		@(posedge mclk);
		rxStart <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	// Mode 0 step down, 1 analog held, 2 no step, 3 step up
	task stepDown(input integer mode);
		if (mode == 3) begin
			if (mD != 3'h7) mD = mD + 3'h1;
			else if (ordBit && mL2 != 2'h3) mL2 = mL2 + 2'h1;
			else if (mL != 2'h3) mL = mL + 2'h1;
			else if (mL2 != 2'h3) mL2 = mL2 + 2'h1;
		end else if (mode == 1) begin
			mD = mD - (mD != 3'h0);
		end else if (mode == 0) begin
			if (ordBit && mL != 2'h0) mL = mL - 2'h1;
			else if (mL2 != 2'h0) mL2 = mL2 - 2'h1;
			else if (mL != 2'h0) mL = mL - 2'h1;
			else if (mD != 3'h0) mD = mD - 3'h1;
		end
	endtask

	// One sample short of a window nothing moves; the last sample steps
	task win(input integer n, input integer mode);
		feed(n - 1, winAmp);
		rd(adG, {1'b0, mD, mL2, mL}, 8'hFF);
		feed(1, winAmp);
		repeat (2) @(posedge mclk);
		stepDown(mode);
		rd(adG, {1'b0, mD, mL2, mL}, 8'hFF);
	endtask

	initial begin
		void'($urandom(88418));
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		rd(adB, 8'h40, 8'hFF);
		rd(adC, 8'h91, 8'hFF);
		rd(16'hDF20, 8'h00, 8'hFF);
		wr(adB, 8'hFF);
		rd(adB, 8'h7F, 8'hFF);
		wr(adG, 8'h00);
		rd(adG, 8'h7F, 8'hFF);
		// Absolute threshold around every goal, random near the boundary
		for (k = 0; k < 128; k = k + 1) begin
			c = k[6:3];
			thr = goalTab[k % 8] + $signed(c);
			rnd = thr + $urandom % 3 - 1;
			goalCode <= k[2:0];
			rssi <= rnd[7:0];
			wr(adB, {4'h4, c});
			repeat (2) @(posedge mclk);
			rd(adF, {7'h00, c != 4'h8 && rnd >= thr}, 8'h01);
		end
		// Relative rise over the floor taken at reception start
		for (k = 0; k < 4; k = k + 1) begin
			wr(adB, {2'h1, k[1:0], 4'h8});
			rssi <= 8'h28;
			rxGo;
			rssi <= 8'h27 + relTab[k][7:0];
			repeat (2) @(posedge mclk);
			rd(adF, 8'h00, 8'h01);
			rssi <= 8'h28 + relTab[k][7:0];
			repeat (2) @(posedge mclk);
			rd(adF, {7'h00, k != 0}, 8'h01);
		end
		wr(adB, 8'h48);
		for (k = 0; k < 4; k = k + 1) begin
			wr(adC, {2'h0, k[1:0], 2'h0, k[1:0]});
			rxGo;
			win(8 * (k + 1) + (8 << k), 0);
		end
		doReset;
		ordBit = 1'b0;
		wr(adB, 8'h08);
		wr(adC, 8'h00);
		rxGo;
		repeat (4) win(16, 0);
		wr(adC, 8'h08);
		win(16, 1);
		wr(adC, 8'h0C);
		win(16, 2);
		rd(adF, 8'h02, 8'h02);
		{overrideLna, overrideLna2, overrideDvga} <= 7'h55;
		overrideLoad <= 1'b1;
		@(posedge mclk);
		overrideLoad <= 1'b0;
		{mL, mL2, mD} = 7'h55;
		repeat (2) @(posedge mclk);
		rd(adG, {1'b0, mD, mL2, mL}, 8'hFF);
		wr(adC, 8'h04);
		rxGo;
		syncFound <= 1'b1;
		@(posedge mclk);
		syncFound <= 1'b0;
		win(16, 2);
		rd(adF, 8'h02, 8'h02);
		rxGo;
		rd(adF, 8'h00, 8'h02);
		ookMode <= 1'b1;
		win(16, 0);
		feed(1, 8'h78);
		rd(adF, 8'h04, 8'h04);
		feed(1, 8'h32);
		rd(adF, 8'h00, 8'h04);
		// Dead zone edges at goal 42: hysteresis 11 is +6/-3, 10 is +4/-2
		wr(adC, 8'hC0);
		winAmp = 8'h30;
		rxGo;
		win(16, 2);
		winAmp = 8'h31;
		rxGo;
		win(16, 0);
		winAmp = 8'h27;
		rxGo;
		win(16, 2);
		winAmp = 8'h26;
		rxGo;
		win(16, 3);
		wr(adC, 8'h80);
		winAmp = 8'h2E;
		rxGo;
		win(16, 2);
		winAmp = 8'h2F;
		rxGo;
		win(16, 0);
		repeat (3) @(posedge mclk);
		wrapUp;
	end

	task doReset;
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		{mL, mL2, mD} = 7'h7F;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		errorCnt = errorCnt + 1;
		wrapUp;
	end
endmodule // agccs_gain_loop_bench

// File: sim/agccs_gain_loop_properties.sv
// Assertion checker for the gain loop register bank
`timescale 1ns/1ns
`include "agccs_regs.vh"

module agccs_gain_loop_properties (
	// Clock, reset, register port
	input wire mclk,
	input wire rstn,
	input wire [15:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWr,
	input wire regRd,
	input wire [7:0] regRdata,
	// Receiver and gains
	input wire [7:0] rssi,
	input wire [2:0] goalCode,
	input wire overrideLoad,
	input wire [1:0] lnaGain,
	input wire [1:0] lna2Gain,
	input wire [2:0] dvgaGain,
	input wire carrierSense,
	input wire gainFrozen
);
	// ----------
	// Shadow registers
	// ----------
	reg [7:0] ctlB;
	reg [7:0] ctlC;
	wire [63:0] goalTab = 64'h2A282624211E1B18;
	wire [1:0] hold = ctlC[3:2];
	wire [7:0] thr = goalTab[{goalCode, 3'h0} +: 8] + {{4{ctlB[3]}}, ctlB[3:0]};
	wire absHit = rssi >= thr;

	always @(posedge mclk) begin
		if (!rstn) begin
			ctlB <= `AGCCS_RST_CTRL_B;
			ctlC <= `AGCCS_RST_CTRL_C;
		end else if (regWr && regAddr == `AGCCS_ADDR_CTRL_B) begin
			ctlB <= {1'b0, regWdata[6:0]};
		end else if (regWr && regAddr == `AGCCS_ADDR_CTRL_C) begin
			ctlC <= regWdata;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	chk_rd_idle: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data not idle");
	chk_rd_ctrlb: assert property (regRd && regAddr == `AGCCS_ADDR_CTRL_B |=> regRdata == $past(ctlB))
		else $error("control b read wrong");
	chk_cs_off: assert property ($past(rstn) && $past(ctlB[5:0]) == 6'h08 |-> !carrierSense)
		else $error("carrier sense with checks off");
	chk_cs_abs: assert property ($past(rstn, 2) && $past(ctlB[5:4]) == 2'h0 &&
		$past(ctlB[3:0]) != `AGCCS_ABS_OFF |-> carrierSense == $past(absHit))
		else $error("absolute carrier sense wrong");
	chk_full_hold: assert property ($past(rstn) && $past(hold, 2) == 2'h3 && $past(hold) == 2'h3 &&
		!$past(overrideLoad) |-> $stable({lnaGain, lna2Gain, dvgaGain}))
		else $error("gain moved under full hold");
	chk_analog_hold: assert property ($past(rstn) && $past(hold, 2) == 2'h2 &&
		$past(hold) == 2'h2 |-> $stable({lnaGain, lna2Gain}))
		else $error("analog gain moved under analog hold");
	chk_frozen_full: assert property ($past(hold) == 2'h3 && hold == 2'h3 |-> gainFrozen)
		else $error("frozen flag low under full hold");
	chk_frozen_none: assert property ($past(hold) == 2'h0 && hold == 2'h0 |-> !gainFrozen)
		else $error("frozen flag high in normal mode");

	cov_read: cover property (regRd ##1 regRdata != 8'h00);
	cov_sense: cover property ($rose(carrierSense));
	cov_override: cover property (hold == 2'h3 && overrideLoad);
endmodule // agccs_gain_loop_properties

bind agccs_gain_loop agccs_gain_loop_properties u_agccs_gain_loop_properties (.mclk, .rstn,
	.regAddr, .regWdata, .regWr, .regRd, .regRdata, .rssi, .goalCode, .overrideLoad, .lnaGain,
	.lna2Gain, .dvgaGain, .carrierSense, .gainFrozen);
